// ### hdl/icsri_map.svh
// Constants for the cache init loader: strap codes, timing and sizes.
// Assumes inclusion by bare name from package and modules.
`ifndef ICSRI_MAP_SVH
`define ICSRI_MAP_SVH
`define ICSRI_STRAP_W 3
`define ICSRI_STRAP_ROM 3'h0
`define ICSRI_STRAP_OFF 3'h1
`define ICSRI_STRAP_EARLY_MASK 3'h3
`define ICSRI_WORD_W 32
`define ICSRI_ADDR_W 11
`define ICSRI_ROM_WORDS 11'h7ff
`define ICSRI_BIT_CNT_W 5
`define ICSRI_ROM_HALF_NS 40
`define ICSRI_CLK_NS 10
`define ICSRI_ROM_HALF_CYC ((`ICSRI_ROM_HALF_NS + `ICSRI_CLK_NS - 1) / `ICSRI_CLK_NS)
`define ICSRI_ROM_RST_NS 200
`define ICSRI_ROM_RST_CYC ((`ICSRI_ROM_RST_NS + `ICSRI_CLK_NS - 1) / `ICSRI_CLK_NS)
`define ICSRI_TMR_W 8
`define ICSRI_DIV_W 4
`define ICSRI_DIV_RATIO 4'h4
`define ICSRI_BUF_DEPTH 2
`endif

// ### hdl/icsri_pkg.sv
// Types for the cache init loader.
// Assumes icsri_map.svh is on the include path.
`include "icsri_map.svh"
package icsri_pkg;
  typedef enum logic [2:0] {
    ICSRI_IDLE = 3'h0,
    ICSRI_ROMRST = 3'h1,
    ICSRI_LOW = 3'h3,
    ICSRI_HIGH = 3'h2,
    ICSRI_PUSH = 3'h6,
    ICSRI_DONE = 3'h7,
    ICSRI_OFF = 3'h5,
    ICSRI_RSVD = 3'h4
  } icsri_state_e;
  typedef logic [`ICSRI_WORD_W-1:0] icsri_word_t;
  typedef logic [`ICSRI_ADDR_W-1:0] icsri_addr_t;
  typedef struct packed {
    icsri_addr_t addr;
    icsri_word_t data;
  } icsri_entry_s;
endpackage

// ### hdl/icsri_stream_if.sv
// Word stream from the serial shifter to the two-entry buffer.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface icsri_stream_if;
  import icsri_pkg::*;
  icsri_entry_s entry;
  logic valid;
  logic ready;
  modport src (output entry, output valid, input ready);
  modport snk (input entry, input valid, output ready);
endinterface // icsri_stream_if

// ### hdl/icsri_pair_buf.sv
// Two-entry buffer between the shifter and the cache write port.
// Assumes the shifter holds valid until ready; outEntry_q and outValid_q are flops, ready is combinational.
`timescale 1ns/1ps
`include "icsri_map.svh"
module icsri_pair_buf
  import icsri_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic flush,
  icsri_stream_if.snk inPort,
  output icsri_entry_s outEntry_q,
  output logic outValid_q,
  input wire logic outReady
);
  icsri_entry_s store_q [`ICSRI_BUF_DEPTH];
  logic [1:0] count_q;
  logic wrPtr_q;
  logic rdPtr_q;
  logic doWr;
  logic doRd;

  // Ready only while a slot is free, so a stalled drain fills and stalls the shifter
  assign inPort.ready = (count_q != 2'h2) && !flush;
  assign doWr = inPort.valid && inPort.ready;
  assign doRd = outValid_q && outReady;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      store_q[0] <= '0;
      store_q[1] <= '0;
      wrPtr_q <= 1'b0;
    end else if (flush) begin
      wrPtr_q <= 1'b0;
    end else if (doWr) begin
      store_q[wrPtr_q] <= inPort.entry;
      wrPtr_q <= ~wrPtr_q;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      count_q <= 2'h0;
      rdPtr_q <= 1'b0;
    end else if (flush) begin
      count_q <= 2'h0;
      rdPtr_q <= 1'b0;
    end else begin
      count_q <= count_q + {1'b0, doWr} - {1'b0, doRd};
      if (doRd) begin
        rdPtr_q <= ~rdPtr_q;
      end
    end
  end

  // Output register shows the head entry; refilled the cycle after a pop
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      outValid_q <= 1'b0;
      outEntry_q <= '0;
    end else if (flush) begin
      outValid_q <= 1'b0;
    end else if (!outValid_q || doRd) begin
      outValid_q <= (count_q - {1'b0, doRd}) != 2'h0 && !(doRd && count_q == 2'h1);
      outEntry_q <= doRd ? store_q[~rdPtr_q] : store_q[rdPtr_q];
    end
  end
endmodule // icsri_pair_buf

// ### hdl/icsri_loader.sv
// Top of the reset-time instruction cache loader.
// Assumes all pins synchronous to mclk and a cache write port with ready.
`timescale 1ns/1ps
`include "icsri_map.svh"
module icsri_loader
  import icsri_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic chipResetN,
  input wire logic laterPart,
  input wire logic [`ICSRI_STRAP_W-1:0] cacheInitSelect,
  output logic romOutputEnableN_q,
  output logic romBitClock_q,
  input wire logic romSerialIn,
  input wire logic supplyGoodClockSwitch,
  output logic clockSelExternal_q,
  input wire logic sysclkDividerClear,
  output logic sysClkOut_q,
  output logic cacheEnabled_q,
  output logic loadDone_q,
  output logic modeReserved_q,
  output icsri_entry_s cacheWrEntry_q,
  output logic cacheWrValid_q,
  input wire logic cacheWrReady
);
  icsri_state_e state_q;
  logic [`ICSRI_STRAP_W-1:0] strap_q;
  logic [`ICSRI_TMR_W-1:0] timer_q;
  logic [`ICSRI_BIT_CNT_W-1:0] bitCnt_q;
  icsri_word_t shift_q;
  icsri_addr_t addr_q;
  logic [`ICSRI_DIV_W-1:0] divCnt_q;
  logic [`ICSRI_STRAP_W-1:0] effStrap;
  logic timerDone;
  logic inReset;
  icsri_stream_if wordLink ();
  logic [1:0] pending_q;
  logic wordPush;
  logic wordPop;

  assign inReset = !chipResetN;
  assign timerDone = (timer_q == '0);

  // Later part decodes all three bits
  assign effStrap = laterPart ? strap_q : (strap_q & `ICSRI_STRAP_EARLY_MASK);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      strap_q <= '0;
    end else if (inReset) begin
      strap_q <= cacheInitSelect;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ICSRI_IDLE;
    end else if (inReset) begin
      state_q <= ICSRI_IDLE;
    end else begin
      case (state_q)
        ICSRI_IDLE: begin
          if (effStrap == `ICSRI_STRAP_ROM) begin
            state_q <= ICSRI_ROMRST;
          end else if (effStrap == `ICSRI_STRAP_OFF) begin
            state_q <= ICSRI_OFF;
          end else begin
            state_q <= ICSRI_RSVD;
          end
        end
        ICSRI_ROMRST: begin
          if (timerDone) begin
            state_q <= ICSRI_LOW;
          end
        end
        ICSRI_LOW: begin
          if (timerDone) begin
            state_q <= ICSRI_HIGH;
          end
        end
        ICSRI_HIGH: begin
          if (timerDone) begin
            state_q <= (bitCnt_q == '1) ? ICSRI_PUSH : ICSRI_LOW;
          end
        end
        ICSRI_PUSH: begin
          // Stalls here while the buffer is full
          if (wordLink.ready) begin
            state_q <= (addr_q == `ICSRI_ROM_WORDS) ? ICSRI_DONE : ICSRI_LOW;
          end
        end
        ICSRI_DONE: state_q <= ICSRI_DONE;
        ICSRI_OFF: state_q <= ICSRI_OFF;
        ICSRI_RSVD: state_q <= ICSRI_RSVD;
        default: state_q <= ICSRI_IDLE;
      endcase
    end
  end

  // Phase timer for ROM reset and bit clock halves
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      timer_q <= '0;
    end else if (inReset || state_q == ICSRI_IDLE) begin
      timer_q <= `ICSRI_TMR_W'(`ICSRI_ROM_RST_CYC - 1);
    end else if (state_q == ICSRI_PUSH) begin
      // Held through a stall so the next low phase is never short
      timer_q <= `ICSRI_TMR_W'(`ICSRI_ROM_HALF_CYC - 1);
    end else if (!timerDone) begin
      timer_q <= timer_q - `ICSRI_TMR_W'(1);
    end else if (state_q == ICSRI_ROMRST || state_q == ICSRI_LOW || state_q == ICSRI_HIGH) begin
      timer_q <= `ICSRI_TMR_W'(`ICSRI_ROM_HALF_CYC - 1);
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      romOutputEnableN_q <= 1'b1;
    end else begin
      // Chip reset raises it at once, so the ROM is reset with the loader
      romOutputEnableN_q <= inReset || !(state_q == ICSRI_LOW || state_q == ICSRI_HIGH || state_q == ICSRI_PUSH);
    end
  end

  // Bit clock high idles, low phase advances ROM
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      romBitClock_q <= 1'b1;
    end else begin
      romBitClock_q <= inReset || (state_q != ICSRI_LOW);
    end
  end

  // Sample bit at end of high phase
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      shift_q <= '0;
      bitCnt_q <= '0;
    end else if (inReset || state_q == ICSRI_IDLE) begin
      bitCnt_q <= '0;
    end else if (state_q == ICSRI_HIGH && timerDone) begin
      shift_q <= {shift_q[`ICSRI_WORD_W-2:0], romSerialIn};
      bitCnt_q <= bitCnt_q + `ICSRI_BIT_CNT_W'(1);
    end
  end

  // Cache address steps once per accepted word
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_q <= '0;
    end else if (inReset || state_q == ICSRI_IDLE) begin
      addr_q <= '0;
    end else if (state_q == ICSRI_PUSH && wordLink.ready) begin
      addr_q <= addr_q + `ICSRI_ADDR_W'(1);
    end
  end

  assign wordLink.valid = (state_q == ICSRI_PUSH);
  assign wordLink.entry = '{addr: addr_q, data: shift_q};

  icsri_pair_buf u_buf (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .flush(inReset),
    .inPort(wordLink.snk),
    .outEntry_q(cacheWrEntry_q),
    .outValid_q(cacheWrValid_q),
    .outReady(cacheWrReady)
  );

  assign wordPush = wordLink.valid && wordLink.ready;
  assign wordPop = cacheWrValid_q && cacheWrReady;

  // Words still in flight; valid alone dips while the buffer head reloads
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pending_q <= 2'h0;
    end else if (inReset) begin
      pending_q <= 2'h0;
    end else begin
      pending_q <= pending_q + {1'b0, wordPush} - {1'b0, wordPop};
    end
  end

  // Status shows the mode chosen at release
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cacheEnabled_q <= 1'b0;
      loadDone_q <= 1'b0;
      modeReserved_q <= 1'b0;
    end else begin
      cacheEnabled_q <= !inReset && (state_q == ICSRI_DONE) && (pending_q == 2'h0);
      loadDone_q <= !inReset && ((state_q == ICSRI_DONE && pending_q == 2'h0) || state_q == ICSRI_OFF);
      modeReserved_q <= !inReset && (state_q == ICSRI_RSVD);
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      clockSelExternal_q <= 1'b0;
    end else begin
      clockSelExternal_q <= supplyGoodClockSwitch;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      divCnt_q <= '0;
      sysClkOut_q <= 1'b0;
    end else if (laterPart && sysclkDividerClear) begin
      divCnt_q <= '0;
      sysClkOut_q <= 1'b0;
    end else if (divCnt_q == `ICSRI_DIV_RATIO - `ICSRI_DIV_W'(1)) begin
      divCnt_q <= '0;
      sysClkOut_q <= ~sysClkOut_q;
    end else begin
      divCnt_q <= divCnt_q + `ICSRI_DIV_W'(1);
    end
  end
endmodule // icsri_loader

// ### tb/icsri_rom_model.sv
// Serial ROM model: one bit per rising bit clock, MSB first.
// Assumes enable high resets the ROM's bit address.
`timescale 1ns/1ps
module icsri_rom_model (
  input wire logic romOutputEnableN,
  input wire logic romBitClock,
  output logic romSerialIn
);
  logic [15:0] bitNum = 16'h0000;
  logic [31:0] word;
  assign word = 32'h8000_0001 + 32'(bitNum[15:5]);
  initial romSerialIn = 1'b0;
  always @(posedge romBitClock or posedge romOutputEnableN) begin
    if (romOutputEnableN) begin
      bitNum <= 16'h0000;
      // Released line shows the inverse, not a stale bit
      romSerialIn <= ~romSerialIn;
    end else begin
      romSerialIn <= word[5'd31 - bitNum[4:0]];
      bitNum <= bitNum + 16'h0001;
    end
  end
endmodule // icsri_rom_model

// ### tb/icsri_loader_monitor.sv
// Checker on the cache init loader ports.
// Assumes bind onto icsri_loader; one clock.
`timescale 1ns/1ps
`include "icsri_map.svh"
module icsri_loader_monitor
  import icsri_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic chipResetN,
  input wire logic laterPart,
  input wire logic [`ICSRI_STRAP_W-1:0] cacheInitSelect,
  input wire logic romOutputEnableN_q,
  input wire logic romBitClock_q,
  input wire logic supplyGoodClockSwitch,
  input wire logic clockSelExternal_q,
  input wire logic sysclkDividerClear,
  input wire logic sysClkOut_q,
  input wire logic cacheEnabled_q,
  input wire logic loadDone_q,
  input wire logic modeReserved_q,
  input wire icsri_entry_s cacheWrEntry_q,
  input wire logic cacheWrValid_q,
  input wire logic cacheWrReady
);
  logic [7:0] hiCnt_q;
  // Saturates so a long idle never wraps below the reset time
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst)
      hiCnt_q <= 8'h00;
    else if (!romOutputEnableN_q)
      hiCnt_q <= 8'h00;
    else if (hiCnt_q != 8'hff)
      hiCnt_q <= hiCnt_q + 8'h01;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst || !chipResetN);
  sequence lowPhase_s;
    !romBitClock_q [*4] ##1 romBitClock_q;
  endsequence
  sequence offPick_s;
    !chipResetN && cacheInitSelect == `ICSRI_STRAP_OFF ##1 chipResetN;
  endsequence
  idle_on_reset_a: assert property (disable iff (sys_rst) !chipResetN |=> romOutputEnableN_q && romBitClock_q)
    else $error("loader not idle in chip reset");
  rom_reset_a: assert property ($fell(romOutputEnableN_q) |-> hiCnt_q >= 8'h14)
    else $error("ROM reset too short");
  bit_phase_a: assert property ($fell(romBitClock_q) |-> lowPhase_s)
    else $error("bit clock low phase wrong");
  valid_hold_a: assert property (cacheWrValid_q && !cacheWrReady |=> cacheWrValid_q && $stable(cacheWrEntry_q))
    else $error("entry dropped while stalled");
  reserved_quiet_a: assert property (modeReserved_q |-> romOutputEnableN_q && !cacheWrValid_q && !loadDone_q)
    else $error("reserved mode not quiet");
  off_mode_a: assert property (disable iff (sys_rst) offPick_s |-> ##[1:3] (loadDone_q && romOutputEnableN_q))
    else $error("disabled mode not reached");
  clock_sel_a: assert property ($changed(supplyGoodClockSwitch) |=> clockSelExternal_q == $past(supplyGoodClockSwitch))
    else $error("clock source not switched");
  div_clear_a: assert property (laterPart && sysclkDividerClear |=> !sysClkOut_q)
    else $error("divider not cleared");
  div_period_a: assert property (disable iff (sys_rst || sysclkDividerClear) $rose(sysClkOut_q) |-> sysClkOut_q [*4] ##1 !sysClkOut_q)
    else $error("divider period wrong");
endmodule // icsri_loader_monitor

// ### tb/testbench.sv
// Self-checking bench for the cache init loader.
// Assumes the ROM model and monitor are compiled first.
`timescale 1ns/1ps
`include "icsri_map.svh"
module testbench;
  import icsri_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic chipResetN = 1'b0;
  logic laterPart = 1'b1;
  logic [`ICSRI_STRAP_W-1:0] cacheInitSelect = 3'h0;
  logic supplyGoodClockSwitch = 1'b0;
  logic sysclkDividerClear = 1'b0;
  logic cacheWrReady = 1'b0;
  logic romOutputEnableN_q, romBitClock_q, romSerialIn, clockSelExternal_q, sysClkOut_q;
  logic cacheEnabled_q, loadDone_q, modeReserved_q, cacheWrValid_q;
  icsri_entry_s cacheWrEntry_q;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  icsri_loader icsri_loader_i (.*);
  icsri_rom_model icsri_rom_model_i (.romOutputEnableN(romOutputEnableN_q), .romBitClock(romBitClock_q),
    .romSerialIn(romSerialIn));
  initial forever #5 mclk = ~mclk;
  task automatic finish_test;
    if (mismatches == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [42:0] got, input logic [42:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Whole run needs about 1100 cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      finish_test();
    end
  end
  task automatic pick(input logic [2:0] s, input logic lp);
    @(posedge mclk);
    #1 chipResetN = 1'b0;
    cacheInitSelect = s;
    laterPart = lp;
    repeat (2) @(posedge mclk);
    #1 chipResetN = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
  endtask
  // Long stall on word 0 fills the buffer and stops the shifter
  task automatic t_rom;
    int i;
    pick(3'h0, 1'b1);
    chk(romOutputEnableN_q, 1'b1);
    for (int w = 0; w < 3; w++) begin
      i = 0;
      while (cacheWrValid_q !== 1'b1 && i < 2000) begin
        @(posedge mclk);
        #1 i++;
      end
      chk(romOutputEnableN_q, 1'b0);
      repeat (w == 0 ? 600 : 3) @(posedge mclk);
      #1 cacheWrReady = 1'b1;
      // Full buffer holds the shifter with the bit clock high
      if (w == 0) begin
        chk(romBitClock_q, 1'b1);
      end
      chk(cacheWrEntry_q, {11'(w), 32'h8000_0001 + 32'(w)});
      @(posedge mclk);
      #1 cacheWrReady = 1'b0;
    end
    chk({cacheEnabled_q, loadDone_q}, 2'h0);
  endtask
  task automatic t_early;
    pick(3'h4, 1'b0);
    repeat (20) @(posedge mclk);
    #1 chk({modeReserved_q, romOutputEnableN_q}, 2'h0);
    pick(3'h5, 1'b0);
    chk({loadDone_q, romOutputEnableN_q}, 2'h3);
    for (int k = 2; k < 4; k++) begin
      pick(3'(k), 1'b0);
      chk(modeReserved_q, 1'b1);
    end
  endtask
  task automatic t_later;
    for (int k = 1; k < 8; k++) begin
      pick(3'(k), 1'b1);
      chk({modeReserved_q, loadDone_q}, {k > 1, k == 1});
    end
  endtask
  task automatic t_clk;
    supplyGoodClockSwitch = 1'b1;
    repeat (2) @(posedge mclk);
    #1 chk(clockSelExternal_q, 1'b1);
    supplyGoodClockSwitch = 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk(clockSelExternal_q, 1'b0);
    sysclkDividerClear = 1'b1;
    repeat (10) @(posedge mclk);
    #1 chk(sysClkOut_q, 1'b0);
    sysclkDividerClear = 1'b0;
    repeat (3) @(posedge mclk);
    #1 chk(sysClkOut_q, 1'b0);
    @(posedge mclk);
    #1 chk(sysClkOut_q, 1'b1);
    // Early part ignores the clear, so the divider keeps running
    laterPart = 1'b0;
    sysclkDividerClear = 1'b1;
    repeat (8) @(posedge mclk);
    #1 chk(sysClkOut_q, 1'b1);
    sysclkDividerClear = 1'b0;
    repeat (20) @(posedge mclk);
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    #1 sys_rst = 1'b0;
    chk({romOutputEnableN_q, romBitClock_q, cacheWrValid_q}, 3'h6);
    t_rom();
    t_early();
    t_later();
    t_clk();
    finish_test();
  end
endmodule // testbench
bind icsri_loader icsri_loader_monitor icsri_loader_monitor_i (.*);
